//--- logic/mcg_defs.svh
// Purpose: offsets, field positions, reset values and timing counts of the gain control block
// Assumes: 8-bit register port, 125 MHz clock
// Notes:   definitions only
`ifndef MCG_DEFS_SVH
`define MCG_DEFS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define MCG_SRC_BASE     8'h00
`define MCG_GAIN_BASE    8'h10
`define MCG_IN_LVL_BASE  8'h40
`define MCG_OUT_LVL_BASE 8'h44
`define MCG_FILT_EN      8'h48
`define MCG_RATE         8'h49
`define MCG_TRIM_BASE    8'h50
`define MCG_TOPO_CTRL    8'h52
`define MCG_TOPO_KEY     8'h53
`define MCG_HP_CTRL_BASE 8'h54
`define MCG_HP_LVL_BASE  8'h56
`define MCG_HP_STAT_BASE 8'h58

// ----------------------------------------
// fields and values
// ----------------------------------------
`define MCG_HP_EN_BIT    7
`define MCG_HP_STAGE_BIT 6
`define MCG_HP_RAMP_BIT  5
`define MCG_HP_ZC_BIT    4
`define MCG_HP_MUTE_BIT  3
`define MCG_HP_FLOOR_BIT 2
`define MCG_TRIM_EN_BIT  7
`define MCG_GAIN_RESET   5'h1c
`define MCG_IN_LVL_RESET 7'h6f
`define MCG_OUT_LVL_RESET 8'h6f
`define MCG_HP_LVL_RESET 6'h3b
`define MCG_HP_LVL_MIN   6'h15
`define MCG_TRIM_RESET   2'h2
`define MCG_TOPO_KEY_VAL 8'hc3
`define MCG_RATE_RESET   4'hb
`define MCG_SR_11K025    4'h2
`define MCG_SR_22K05     4'h5
`define MCG_SR_44K1      4'ha
`define MCG_SR_88K2      4'he

// ----------------------------------------
// timing
// ----------------------------------------
`define MCG_CLK_MHZ      125
`define MCG_ZC_TIMEOUT_US 100000
`define MCG_ZC_TIMEOUT_CYCLES (`MCG_ZC_TIMEOUT_US * `MCG_CLK_MHZ)
`define MCG_RAMP_STEP_CYCLES 1024

`endif

//--- logic/mcg_pkg.sv
// Purpose: carrier types of the gain control block
// Assumes: nothing
// Notes:   constants live in mcg_defs.svh
package mcg_pkg;
  typedef struct packed {
    logic [5:0][6:0]      source;
    logic [5:0][6:0][4:0] gain;
  } mcg_mix_type;

  typedef struct packed {
    logic [3:0][6:0] input_level;
    logic [1:0][7:0] output_level;
  } mcg_levels_type;

  typedef struct packed {
    logic       enable;
    logic [1:0] level;
  } mcg_trim_type;

  typedef struct packed {
    logic       enable;
    logic       stage_enable;
    logic       mute;
    logic [5:0] level;
    logic [1:0] sub;
  } mcg_phones_type;
endpackage

//--- logic/mcg_phones_ramp.sv
// Purpose: applies one headphone level with ramp, zero-cross wait or at once
// Assumes: zero_cross already synchronised to CLK
// Notes:   level and sub-step are one counter, four sub-steps per 1.5 dB
`timescale 1ns/100ps
`include "mcg_defs.svh"
module mcg_phones_ramp #(
  parameter int unsigned ZC_TIMEOUT_CYCLES = `MCG_ZC_TIMEOUT_CYCLES,
  parameter int unsigned RAMP_STEP_CYCLES  = `MCG_RAMP_STEP_CYCLES
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rstn,
  // control
  input  wire logic [5:0] target,
  input  wire logic       ramp_en,
  input  wire logic       zc_en,
  input  wire logic       zero_cross,
  // applied setting
  output logic      [5:0] level,
  output logic      [1:0] sub
);
  localparam int ZW = $clog2(ZC_TIMEOUT_CYCLES + 1);
  localparam int SW = $clog2(RAMP_STEP_CYCLES + 1);

  logic [7:0]    pos;
  logic [7:0]    goal;
  logic [ZW-1:0] zc_cnt;
  logic [SW-1:0] step_cnt;
  logic          zc_prev;
  logic          zc_edge;
  logic          zc_last;
  logic          step_tick;

  assign goal      = {target, 2'b00};
  assign zc_edge   = zero_cross && !zc_prev;
  assign zc_last   = zc_cnt == ZW'(ZC_TIMEOUT_CYCLES - 1);
  assign step_tick = step_cnt == SW'(RAMP_STEP_CYCLES - 1);
  assign level     = pos[7:2];
  assign sub       = pos[1:0];

  always_ff @(posedge clk)
  begin
    if (!rstn)
      zc_prev <= 1'b0;
    else
      zc_prev <= zero_cross;
  end

  // ----------------------------------------
  // applied level
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rstn)
      pos <= {`MCG_HP_LVL_RESET, 2'b00};
    else if (pos != goal)
    begin
      if (ramp_en)
      begin
        if (step_tick)
          pos <= (pos < goal) ? pos + 8'd1 : pos - 8'd1;
      end
      else if (zc_en)
      begin
        if (zc_edge || zc_last)
          pos <= goal;
      end
      else
        pos <= goal;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rstn || !ramp_en || pos == goal || step_tick)
      step_cnt <= '0;
    else
      step_cnt <= step_cnt + SW'(1);
  end

  // timeout restarts whenever nothing waits, so a new change gets the full wait
  always_ff @(posedge clk)
  begin
    if (!rstn || ramp_en || !zc_en || pos == goal || zc_last)
      zc_cnt <= '0;
    else
      zc_cnt <= zc_cnt + ZW'(1);
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_ramp_step;
    @(posedge clk) disable iff (!rstn)
    ramp_en |=> (pos == $past(pos)) || (pos == $past(pos) + 8'd1) || (pos == $past(pos) - 8'd1);
  endproperty
  a_ramp_step: assert property (p_ramp_step) else $error("ramp jumped");

  property p_zc_hold;
    @(posedge clk) disable iff (!rstn)
    !ramp_en && zc_en && pos != goal && !zc_edge && !zc_last |=> pos == $past(pos);
  endproperty
  a_zc_hold: assert property (p_zc_hold) else $error("level moved before zero cross");

  property p_zc_timeout;
    @(posedge clk) disable iff (!rstn)
    !ramp_en && zc_en && pos != goal && zc_last |=> pos == $past(goal);
  endproperty
  a_zc_timeout: assert property (p_zc_timeout) else $error("timeout not applied");
endmodule // mcg_phones_ramp

//--- logic/mcg_top.sv
// Purpose: mixer crosspoints, digital levels, DAC enables and headphone gain control
// Assumes: one 125 MHz clock, register port answers reads one cycle later
// Notes:   zero-cross pins arrive asynchronously and are synchronised here
//
// The implementer's own choices: the register offsets and strobed register access.
`timescale 1ns/100ps
`include "mcg_defs.svh"
// How it works
// - seven inputs to six outputs, gain each
// - source bit set passes, cleared blocks input
// - five-bit path gain, -42 dB in 1.5 steps
// - path gains reset to 0 dB code
// - four input levels, 0.75 dB steps
// - two output levels up to +108 dB
// - DAC channel follows its output filter enable
// - DAC clock chosen by sample rate family
// - trim buffer enable, gain applied at once
// - direct supply bit needs key 0xc3 first
// - amplifier and output stage enables separate
// - headphone level -57 to +6 dB
// - ramp walks every sub-step, overrides zero-cross
// - zero-cross wait with fixed 0.1 s timeout
// - mute bit silences the amplifier
// - floor bit forces minimum, ramped, synchronised or at once
module mcg_top
  import mcg_pkg::*;
#(
  parameter int unsigned ZC_TIMEOUT_CYCLES = `MCG_ZC_TIMEOUT_CYCLES,
  parameter int unsigned RAMP_STEP_CYCLES  = `MCG_RAMP_STEP_CYCLES
) (
  // clock and reset
  input  wire logic                      CLK,
  input  wire logic                      RSTN,
  // register port
  input  wire logic [7:0]                ADDR,
  input  wire logic [7:0]                WDATA,
  input  wire logic                      WR,
  input  wire logic                      RD,
  output logic      [7:0]                RDATA,
  // zero-cross detector pins
  input  wire logic                      ZERO_CROSS_L,
  input  wire logic                      ZERO_CROSS_R,
  // digital mixer and levels
  output mcg_pkg::mcg_mix_type           MIX,
  output mcg_pkg::mcg_levels_type        LEVELS,
  // DAC
  output logic      [1:0]                DAC_ENABLE,
  output logic                           DAC_CLK_SELECT,
  // headphone path
  output mcg_pkg::mcg_trim_type   [1:0]  TRIM,
  output logic                           PHONES_BALANCED,
  output logic                           PHONES_DIRECT_SUPPLY,
  output mcg_pkg::mcg_phones_type [1:0]  PHONES
);
  import mcg_pkg::*;

  logic [1:0]      filt_en;
  logic [3:0]      playback_sample_rate;
  logic            unlocked;
  logic [1:0][7:0] hp_ctrl;
  logic [1:0][5:0] hp_level_req;
  logic [1:0][5:0] hp_target;
  logic [1:0][5:0] hp_level;
  logic [1:0][1:0] hp_sub;
  logic [1:0]      zc_meta;
  logic [1:0]      zc_sync;
  logic [2:0]      g_out;
  logic [2:0]      g_in;
  logic            gain_hit;
  logic [7:0]      rd_value;
  logic            rate_44k1;

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  assign g_out    = ADDR[5:3] - 3'd2;
  assign g_in     = ADDR[2:0];
  assign gain_hit = ADDR[7:6] == 2'b00 && ADDR[5:4] != 2'b00 && g_in != 3'd7;

  // ----------------------------------------
  // mixer crosspoints
  // ----------------------------------------
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
    begin
      MIX.source <= '0;
      MIX.gain   <= {42{`MCG_GAIN_RESET}};
    end
    else if (WR)
    begin
      if (ADDR[7:3] == 5'h00 && ADDR[2:0] < 3'd6)
        MIX.source[ADDR[2:0]] <= WDATA[6:0];
      if (gain_hit)
        MIX.gain[g_out][g_in] <= WDATA[4:0];
    end
  end

  // ----------------------------------------
  // channel digital levels
  // ----------------------------------------
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
      LEVELS <= {{4{`MCG_IN_LVL_RESET}}, {2{`MCG_OUT_LVL_RESET}}};
    else if (WR)
    begin
      if (ADDR[7:2] == `MCG_IN_LVL_BASE >> 2)
        LEVELS.input_level[ADDR[1:0]] <= WDATA[6:0];
      if (ADDR[7:1] == `MCG_OUT_LVL_BASE >> 1)
        LEVELS.output_level[ADDR[0]] <= WDATA;
    end
  end

  // ----------------------------------------
  // DAC enable and clock
  // ----------------------------------------
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
      {filt_en, playback_sample_rate} <= {2'b00, `MCG_RATE_RESET};
    else if (WR)
    begin
      if (ADDR == `MCG_FILT_EN)
        filt_en <= WDATA[1:0];
      if (ADDR == `MCG_RATE)
        playback_sample_rate <= WDATA[3:0];
    end
  end

  assign rate_44k1 = playback_sample_rate == `MCG_SR_11K025
                  || playback_sample_rate == `MCG_SR_22K05
                  || playback_sample_rate == `MCG_SR_44K1
                  || playback_sample_rate == `MCG_SR_88K2;

  // select high means the slower 44.1 kHz family clock
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
      {DAC_ENABLE, DAC_CLK_SELECT} <= 3'h0;
    else
      {DAC_ENABLE, DAC_CLK_SELECT} <= {filt_en, rate_44k1};
  end

  // ----------------------------------------
  // trim buffers
  // ----------------------------------------
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
      TRIM <= {2{1'b0, `MCG_TRIM_RESET}};
    else if (WR && ADDR[7:1] == `MCG_TRIM_BASE >> 1)
      TRIM[ADDR[0]] <= '{WDATA[`MCG_TRIM_EN_BIT], WDATA[1:0]};
  end

  // ----------------------------------------
  // topology and protected supply bit
  // ----------------------------------------
  // the key is spent by the next write to the control register, so one unlock
  // never leaves the supply bit open for later stray writes
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
      unlocked <= 1'b0;
    else if (WR && ADDR == `MCG_TOPO_KEY)
      unlocked <= WDATA == `MCG_TOPO_KEY_VAL;
    else if (WR && ADDR == `MCG_TOPO_CTRL)
      unlocked <= 1'b0;
  end

  // reset leaves balanced mode off; software has to turn it on
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
      {PHONES_BALANCED, PHONES_DIRECT_SUPPLY} <= 2'h0;
    else if (WR && ADDR == `MCG_TOPO_CTRL)
    begin
      PHONES_BALANCED <= WDATA[0];
      if (unlocked)
        PHONES_DIRECT_SUPPLY <= WDATA[1];
    end
  end

  // ----------------------------------------
  // headphone controls
  // ----------------------------------------
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
    begin
      hp_ctrl      <= '0;
      hp_level_req <= {2{`MCG_HP_LVL_RESET}};
    end
    else if (WR)
    begin
      if (ADDR[7:1] == `MCG_HP_CTRL_BASE >> 1)
        hp_ctrl[ADDR[0]] <= WDATA;
      if (ADDR[7:1] == `MCG_HP_LVL_BASE >> 1)
        hp_level_req[ADDR[0]] <= (WDATA[5:0] < `MCG_HP_LVL_MIN) ? `MCG_HP_LVL_MIN
                                                               : WDATA[5:0];
    end
  end

  // two flops per pin before anything looks at it
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
      {zc_sync, zc_meta} <= 4'h0;
    else
      {zc_sync, zc_meta} <= {zc_meta, ZERO_CROSS_R, ZERO_CROSS_L};
  end

  for (genvar c = 0; c < 2; c++)
  begin : g_phones
    assign hp_target[c] = hp_ctrl[c][`MCG_HP_FLOOR_BIT] ? `MCG_HP_LVL_MIN
                                                         : hp_level_req[c];

    mcg_phones_ramp #(
      .ZC_TIMEOUT_CYCLES (ZC_TIMEOUT_CYCLES),
      .RAMP_STEP_CYCLES  (RAMP_STEP_CYCLES)
    ) u_ramp (
      .clk        (CLK),
      .rstn       (RSTN),
      .target     (hp_target[c]),
      .ramp_en    (hp_ctrl[c][`MCG_HP_RAMP_BIT]),
      .zc_en      (hp_ctrl[c][`MCG_HP_ZC_BIT]),
      .zero_cross (zc_sync[c]),
      .level      (hp_level[c]),
      .sub        (hp_sub[c])
    );

    assign PHONES[c] = '{hp_ctrl[c][`MCG_HP_EN_BIT],
                         hp_ctrl[c][`MCG_HP_STAGE_BIT],
                         hp_ctrl[c][`MCG_HP_MUTE_BIT],
                         hp_level[c], hp_sub[c]};
  end

  // ----------------------------------------
  // read back
  // ----------------------------------------
  always_comb
  begin
    rd_value = 8'h00;
    if (ADDR[7:3] == 5'h00 && ADDR[2:0] < 3'd6)
      rd_value = {1'b0, MIX.source[ADDR[2:0]]};
    else if (gain_hit)
      rd_value = {3'h0, MIX.gain[g_out][g_in]};
    else if (ADDR[7:2] == `MCG_IN_LVL_BASE >> 2)
      rd_value = {1'b0, LEVELS.input_level[ADDR[1:0]]};
    else if (ADDR[7:1] == `MCG_OUT_LVL_BASE >> 1)
      rd_value = LEVELS.output_level[ADDR[0]];
    else if (ADDR == `MCG_FILT_EN)
      rd_value = {4'h0, DAC_ENABLE, filt_en};
    else if (ADDR == `MCG_RATE)
      rd_value = {3'h0, DAC_CLK_SELECT, playback_sample_rate};
    else if (ADDR[7:1] == `MCG_TRIM_BASE >> 1)
      rd_value = {TRIM[ADDR[0]].enable, 5'h00, TRIM[ADDR[0]].level};
    else if (ADDR == `MCG_TOPO_CTRL)
      rd_value = {6'h00, PHONES_DIRECT_SUPPLY, PHONES_BALANCED};
    else if (ADDR[7:1] == `MCG_HP_CTRL_BASE >> 1)
      rd_value = hp_ctrl[ADDR[0]];
    else if (ADDR[7:1] == `MCG_HP_LVL_BASE >> 1)
      rd_value = {2'h0, hp_level_req[ADDR[0]]};
    else if (ADDR[7:1] == `MCG_HP_STAT_BASE >> 1)
      rd_value = {hp_sub[ADDR[0]], hp_level[ADDR[0]]};
  end

  always_ff @(posedge CLK)
  begin
    if (!RSTN)
      RDATA <= 8'h00;
    else
      RDATA <= RD ? rd_value : 8'h00;
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_src_write;
    @(posedge CLK) disable iff (!RSTN)
    WR && ADDR[7:3] == 5'h00 && ADDR[2:0] < 3'd6
      |=> MIX.source[$past(ADDR[2:0])] == $past(WDATA[6:0]);
  endproperty
  a_src_write: assert property (p_src_write) else $error("source select not stored");

  property p_gain_reset;
    @(posedge CLK) disable iff (!RSTN)
    !$past(RSTN) |-> MIX.gain == {42{`MCG_GAIN_RESET}};
  endproperty
  a_gain_reset: assert property (p_gain_reset) else $error("path gain not 0 dB after reset");

  property p_dac_follow;
    @(posedge CLK) disable iff (!RSTN)
    WR && ADDR == `MCG_FILT_EN ##1 !(WR && ADDR == `MCG_FILT_EN)
      |=> DAC_ENABLE == $past(WDATA[1:0], 2);
  endproperty
  a_dac_follow: assert property (p_dac_follow) else $error("DAC enable not following filter");

  property p_clk_family;
    @(posedge CLK) disable iff (!RSTN)
    WR && ADDR == `MCG_RATE && WDATA[3:0] == `MCG_SR_44K1 ##1 !(WR && ADDR == `MCG_RATE)
      |=> DAC_CLK_SELECT;
  endproperty
  a_clk_family: assert property (p_clk_family) else $error("wrong DAC clock family");

  property p_lock;
    @(posedge CLK) disable iff (!RSTN)
    WR && ADDR == `MCG_TOPO_CTRL && !unlocked |=> $stable(PHONES_DIRECT_SUPPLY);
  endproperty
  a_lock: assert property (p_lock) else $error("locked supply bit changed");

  property p_unlock;
    @(posedge CLK) disable iff (!RSTN)
    WR && ADDR == `MCG_TOPO_KEY && WDATA == `MCG_TOPO_KEY_VAL ##1 WR && ADDR == `MCG_TOPO_CTRL
      |=> PHONES_DIRECT_SUPPLY == $past(WDATA[1]);
  endproperty
  a_unlock: assert property (p_unlock) else $error("unlocked write refused");

  property p_trim;
    @(posedge CLK) disable iff (!RSTN)
    WR && ADDR == `MCG_TRIM_BASE |=> TRIM[0].level == $past(WDATA[1:0]);
  endproperty
  a_trim: assert property (p_trim) else $error("trim not applied at once");

  property p_mute;
    @(posedge CLK) disable iff (!RSTN)
    WR && ADDR == `MCG_HP_CTRL_BASE |=> PHONES[0].mute == $past(WDATA[`MCG_HP_MUTE_BIT]);
  endproperty
  a_mute: assert property (p_mute) else $error("mute not applied");

  property p_floor;
    @(posedge CLK) disable iff (!RSTN)
    WR && ADDR == `MCG_HP_CTRL_BASE && WDATA[`MCG_HP_FLOOR_BIT]
      && !WDATA[`MCG_HP_RAMP_BIT] && !WDATA[`MCG_HP_ZC_BIT]
      ##1 !(WR && ADDR == `MCG_HP_CTRL_BASE) |=> PHONES[0].level == `MCG_HP_LVL_MIN;
  endproperty
  a_floor: assert property (p_floor) else $error("floor level not reached");
endmodule // mcg_top

//--- dv/mcg_top_test.sv
// Purpose: self-checking bench for the gain control block over its register port
// Assumes: shortened zero-cross timeout and ramp step parameters
// Notes:   right zero-cross pin is held low; the left channel carries all headphone level tests
`timescale 1ns/100ps
`include "mcg_defs.svh"
module mcg_top_test;
  import mcg_pkg::*;

  // ----------------------------------------
  // signals
  // ----------------------------------------
  localparam int unsigned ZC_CYC   = 50;
  localparam int unsigned RAMP_CYC = 4;
  logic                   CLK;
  logic                   RSTN;
  logic [7:0]             ADDR;
  logic [7:0]             WDATA;
  logic                   WR;
  logic                   RD;
  logic [7:0]             RDATA;
  logic                   ZERO_CROSS_L;
  logic                   ZERO_CROSS_R;
  mcg_mix_type            MIX;
  mcg_levels_type         LEVELS;
  logic [1:0]             DAC_ENABLE;
  logic                   DAC_CLK_SELECT;
  mcg_trim_type   [1:0]   TRIM;
  logic                   PHONES_BALANCED;
  logic                   PHONES_DIRECT_SUPPLY;
  mcg_phones_type [1:0]   PHONES;
  int                     fail_count;
  int                     check_count;
  logic                   sub_seen;
  int                     steps;
  logic [3:0]             rates [6] = '{4'h2, 4'h5, 4'ha, 4'he, 4'h3, 4'hb};

  mcg_top #(.ZC_TIMEOUT_CYCLES(ZC_CYC), .RAMP_STEP_CYCLES(RAMP_CYC)) dut (
    .CLK(CLK), .RSTN(RSTN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .ZERO_CROSS_L(ZERO_CROSS_L), .ZERO_CROSS_R(ZERO_CROSS_R),
    .MIX(MIX), .LEVELS(LEVELS), .DAC_ENABLE(DAC_ENABLE), .DAC_CLK_SELECT(DAC_CLK_SELECT),
    .TRIM(TRIM), .PHONES_BALANCED(PHONES_BALANCED),
    .PHONES_DIRECT_SUPPLY(PHONES_DIRECT_SUPPLY), .PHONES(PHONES)
  );

  always #4 CLK = ~CLK;

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // strobe lowered then one idle edge, so back-to-back calls never touch WR twice at once
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge CLK);
    ADDR  <= a;
    WDATA <= d;
    WR    <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
    @(posedge CLK);
    #1;
  endtask

  // requests start on a rising edge; read data is taken in the one cycle it stands
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge CLK);
    ADDR <= a;
    RD   <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    #1;
    chk(RDATA, exp);
  endtask

  // waits for the applied left level, noting any sub-step seen on the way
  task automatic wait_lvl(input logic [5:0] exp, input int bound);
    steps = 0;
    while (PHONES[0].level !== exp)
    begin
      if (PHONES[0].sub !== 2'h0)
        sub_seen = 1'b1;
      @(posedge CLK);
      #1;
      steps++;
      if (steps > bound)
      begin
        chk(8'hee, {2'h0, exp});
        tally_and_finish();
      end
    end
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    CLK = 0; RSTN = 0; ADDR = 0; WDATA = 0; WR = 0; RD = 0;
    ZERO_CROSS_L = 0; ZERO_CROSS_R = 0;
    fail_count = 0; check_count = 0; sub_seen = 0; steps = 0;
    repeat (2) @(posedge CLK);
    RSTN <= 1'b1;
    @(posedge CLK);
    // reset values and unmapped places
    rd(8'h10, 8'h1c);
    rd(8'h3e, 8'h1c);
    chk({3'h0, MIX.gain[5][6]}, 8'h1c);
    rd(8'h40, 8'h6f);
    rd(8'h49, 8'h0b);
    rd(8'h56, 8'h3b);
    rd(8'h53, 8'h00);
    wr(8'h17, 8'h55);
    rd(8'h17, 8'h00);
    rd(8'hff, 8'h00);
    // crosspoints: last output, last input, code ends
    wr(8'h00, 8'h05);
    chk({1'b0, MIX.source[0]}, 8'h05);
    rd(8'h00, 8'h05);
    wr(8'h3e, 8'h1f);
    chk({3'h0, MIX.gain[5][6]}, 8'h1f);
    wr(8'h3e, 8'h00);
    rd(8'h3e, 8'h00);
    chk({3'h0, MIX.gain[5][5]}, 8'h1c);
    // digital levels at top of range
    wr(8'h43, 8'h7f);
    chk({1'b0, LEVELS.input_level[3]}, 8'h7f);
    wr(8'h45, 8'hff);
    chk(LEVELS.output_level[1], 8'hff);
    chk(LEVELS.output_level[0], 8'h6f);
    // DAC channels follow filter enables one at a time
    wr(8'h48, 8'h02);
    chk({6'h0, DAC_ENABLE}, 8'h02);
    rd(8'h48, 8'h0a);
    wr(8'h48, 8'h01);
    rd(8'h48, 8'h05);
    for (int i = 0; i < 6; i++)
    begin
      wr(8'h49, {4'h0, rates[i]});
      chk({7'h0, DAC_CLK_SELECT}, {7'h0, i < 4});
      rd(8'h49, {3'h0, i < 4, rates[i]});
    end
    // trim applies straight away
    wr(8'h51, 8'h81);
    chk({5'h0, TRIM[1]}, 8'h05);
    chk({5'h0, TRIM[0]}, 8'h02);
    wr(8'h50, 8'h80);
    chk({5'h0, TRIM[0]}, 8'h04);
    // supply bit lock
    wr(8'h52, 8'h03);
    rd(8'h52, 8'h01);
    chk({6'h0, PHONES_DIRECT_SUPPLY, PHONES_BALANCED}, 8'h01);
    wr(8'h53, `MCG_TOPO_KEY_VAL);
    wr(8'h52, 8'h03);
    chk({7'h0, PHONES_DIRECT_SUPPLY}, 8'h01);
    wr(8'h53, 8'h5a);
    wr(8'h52, 8'h01);
    rd(8'h52, 8'h03);
    // key and control write back to back, clearing the supply bit
    @(posedge CLK);
    ADDR  <= 8'h53;
    WDATA <= `MCG_TOPO_KEY_VAL;
    WR    <= 1'b1;
    @(posedge CLK);
    ADDR  <= 8'h52;
    WDATA <= 8'h01;
    @(posedge CLK);
    WR    <= 1'b0;
    rd(8'h52, 8'h01);
    // enables and mute
    wr(8'h54, 8'hc8);
    chk({5'h0, PHONES[0].enable, PHONES[0].stage_enable, PHONES[0].mute}, 8'h07);
    chk({5'h0, PHONES[1].enable, PHONES[1].stage_enable, PHONES[1].mute}, 8'h00);
    wr(8'h55, 8'h40);
    chk({7'h0, PHONES[1].stage_enable}, 8'h01);
    chk({7'h0, PHONES[1].enable}, 8'h00);
    // level with neither ramp nor zero-cross
    wr(8'h56, 8'h05);
    rd(8'h56, 8'h15);
    wait_lvl(6'h15, 4);
    wr(8'h56, 8'h20);
    cycles(1);
    chk({2'h0, PHONES[0].level}, 8'h20);
    rd(8'h58, 8'h20);
    // ramp wins over zero-cross and walks sub-steps
    wr(8'h54, 8'hf8);
    sub_seen = 0;
    wr(8'h56, 8'h22);
    cycles(2);
    chk({2'h0, PHONES[0].level}, 8'h20);
    wait_lvl(6'h22, 100);
    chk({7'h0, sub_seen}, 8'h01);
    chk({7'h0, steps >= 20}, 8'h01);
    rd(8'h58, 8'h22);
    // zero-cross wait, then timeout
    wr(8'h54, 8'hd8);
    wr(8'h56, 8'h30);
    cycles(10);
    chk({2'h0, PHONES[0].level}, 8'h22);
    @(posedge CLK);
    ZERO_CROSS_L <= 1'b1;
    repeat (2) @(posedge CLK);
    ZERO_CROSS_L <= 1'b0;
    wait_lvl(6'h30, 8);
    wr(8'h56, 8'h31);
    cycles(30);
    chk({2'h0, PHONES[0].level}, 8'h30);
    wait_lvl(6'h31, 40);
    // floor level through zero-cross timeout, then at once
    wr(8'h54, 8'hdc);
    cycles(10);
    chk({2'h0, PHONES[0].level}, 8'h31);
    wait_lvl(6'h15, 60);
    wr(8'h54, 8'hc0);
    chk({7'h0, PHONES[0].mute}, 8'h00);
    wait_lvl(6'h31, 4);
    wr(8'h54, 8'hc4);
    wait_lvl(6'h15, 4);
    chk({2'h0, PHONES[0].level}, 8'h15);
    tally_and_finish();
  end
endmodule // mcg_top_test
